// ---- src/aprc_defs.svh ----
// Constants for the converter readout control block
`ifndef APRC_DEFS_SVH
`define APRC_DEFS_SVH
`define APRC_CLK_NS        100
`define APRC_CONV_PULSE_NS 40
`define APRC_CONV_PULSE_CYC ((`APRC_CONV_PULSE_NS + `APRC_CLK_NS - 1) / `APRC_CLK_NS)
`define APRC_BUSY_MAX_NS   2000
`define APRC_BUSY_MAX_CYC  (`APRC_BUSY_MAX_NS / `APRC_CLK_NS)
`define APRC_SETUP_NS      35
`define APRC_SETUP_CYC     ((`APRC_SETUP_NS + `APRC_CLK_NS - 1) / `APRC_CLK_NS)
`define APRC_HOLD_NS       1500
`define APRC_HOLD_CYC      ((`APRC_HOLD_NS + `APRC_CLK_NS - 1) / `APRC_CLK_NS)
`define APRC_CODE_POS_FS   16'h7fff
`define APRC_CODE_MID      16'h0000
`define APRC_CODE_NEG_FS   16'h8000
`define APRC_RESULT_RST    16'h0000
`define APRC_FIFO_DEPTH    16
`define APRC_FIFO_AW       4
`endif

// ---- src/aprc_pkg.sv ----
// Types for the converter readout control block
package aprc_pkg;
  typedef logic [15:0] aprc_word_t;
  typedef enum logic [1:0] {
    APRC_IDLE = 2'b00,
    APRC_CONV = 2'b01,
    APRC_LOAD = 2'b11,
    APRC_DONE = 2'b10
  } aprc_state_t;
endpackage

// ---- src/aprc_fifo.sv ----
// Parameterised flip-flop FIFO
`timescale 1ns/1ps
`default_nettype none
module aprc_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
)
(
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             doWr;
  logic             doRd;

  assign inReady  = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != '0);
  assign outData  = mem_reg[rdPtr_reg];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_ff @(posedge clk_sys)
  begin
    if (doWr)
      mem_reg[wrPtr_reg] <= inData;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (doWr)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (doRd)
        rdPtr_reg <= rdPtr_reg + 1'b1;
      if (doWr && !doRd)
        count_reg <= count_reg + 1'b1;
      else if (doRd && !doWr)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- src/aprc_top.sv ----
// Conversion control and parallel result readout
`timescale 1ns/1ps
`default_nettype none
`include "aprc_defs.svh"
module aprc_top
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              selectN,
  input  wire logic              readConvert,
  input  wire logic              byteSel,
  input  wire aprc_pkg::aprc_word_t sampleData,
  input  wire logic              sampleValid,
  output logic                   sampleReady,
  output logic                   busyN,
  output aprc_pkg::aprc_word_t   resultBusOut,
  output logic                   resultBusOe
);
  import aprc_pkg::*;

  localparam logic [4:0] PULSE_CYC = 5'(`APRC_CONV_PULSE_CYC);
  localparam logic [4:0] BUSY_CYC  = 5'(`APRC_BUSY_MAX_CYC);
  localparam logic [4:0] SETUP_CYC = 5'(`APRC_SETUP_CYC);

  // ==========================================================
  // Input buffer of converted samples
  aprc_word_t  fifoData;
  logic        fifoValid;
  logic        fifoPop;

  aprc_fifo #(
    .WIDTH (16),
    .DEPTH (`APRC_FIFO_DEPTH),
    .AW    (`APRC_FIFO_AW)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .inData   (sampleData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  // ==========================================================
  // Start and abort detection
  aprc_state_t state_reg;
  logic [4:0]  lowCnt_reg;
  logic [4:0]  convCnt_reg;
  logic        startLvl;
  logic        startHit;
  logic        abortHit;
  logic        armed_reg;

  assign startLvl = !selectN && !readConvert;
  assign startHit = armed_reg && startLvl
                    && (state_reg == APRC_IDLE)
                    && ({1'b0, lowCnt_reg} + 6'd1 >= {1'b0, PULSE_CYC});
  assign abortHit = (state_reg == APRC_CONV) && !readConvert
                    && ({1'b0, lowCnt_reg} + 6'd1 >= {1'b0, PULSE_CYC});

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      lowCnt_reg <= '0;
    else if (state_reg == APRC_CONV ? readConvert : !startLvl)
      lowCnt_reg <= '0;
    else if (lowCnt_reg != 5'h1f)
      lowCnt_reg <= lowCnt_reg + 5'd1;
  end

  // Re-armed only once the start combination has been released
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      armed_reg <= 1'b0;
    else if (!startLvl)
      armed_reg <= 1'b1;
    else if (startHit || state_reg != APRC_IDLE)
      armed_reg <= 1'b0;
  end

  // ==========================================================
  // Conversion sequencer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg   <= APRC_IDLE;
      convCnt_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        APRC_IDLE:
        begin
          convCnt_reg <= '0;
          if (startHit)
            state_reg <= APRC_CONV;
        end
        APRC_CONV:
        begin
          convCnt_reg <= convCnt_reg + 5'd1;
          if (abortHit)
            state_reg <= APRC_IDLE;
          else if (convCnt_reg + 5'd1 >= BUSY_CYC - SETUP_CYC - 5'd2)
            state_reg <= APRC_LOAD;
        end
        APRC_LOAD:
        begin
          convCnt_reg <= '0;
          state_reg   <= APRC_DONE;
        end
        APRC_DONE:
        begin
          // Bus register settles one full cycle before busy rises
          convCnt_reg <= convCnt_reg + 5'd1;
          if (convCnt_reg >= SETUP_CYC)
            state_reg <= APRC_IDLE;
        end
      endcase
    end
  end

  assign busyN   = (state_reg == APRC_IDLE);
  assign fifoPop = (state_reg == APRC_LOAD);

  // ==========================================================
  // Output register of results
  aprc_word_t result_reg;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      result_reg <= `APRC_RESULT_RST;
    else if (state_reg == APRC_LOAD)
      result_reg <= fifoValid ? fifoData : `APRC_CODE_MID;
  end

  // ==========================================================
  // Result bus drivers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      resultBusOut <= '0;
    else if (byteSel)
      resultBusOut <= {result_reg[7:0], result_reg[15:8]};
    else
      resultBusOut <= result_reg;
  end

  assign resultBusOe = readConvert && !selectN;

  // ==========================================================
  // Checks
  property p_busy_bounded;
    @(posedge clk_sys) disable iff (!nrst)
    $fell(busyN) |-> ##[1:20] busyN;
  endproperty
  a_busy_bounded: assert property (p_busy_bounded)
    else $error("busy low too long");

  property p_oe_follow;
    @(posedge clk_sys) disable iff (!nrst)
    resultBusOe == (readConvert && !selectN);
  endproperty
  a_oe_follow: assert property (p_oe_follow)
    else $error("bus enable wrong");

  property p_hold_old;
    @(posedge clk_sys) disable iff (!nrst)
    (state_reg == APRC_CONV) |=> $stable(result_reg);
  endproperty
  a_hold_old: assert property (p_hold_old)
    else $error("result changed mid conversion");

  property p_load_first;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(busyN) && ($past(state_reg) != APRC_CONV)
      |-> $past(state_reg, 3) == APRC_LOAD;
  endproperty
  a_load_first: assert property (p_load_first)
    else $error("busy rose without load");

  property p_data_setup;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(busyN) && ($past(state_reg) == APRC_DONE)
      && ($past(byteSel, 2) == $past(byteSel)) |-> $stable(resultBusOut);
  endproperty
  a_data_setup: assert property (p_data_setup)
    else $error("result bus changed as busy rose");

  property p_abort_release;
    @(posedge clk_sys) disable iff (!nrst)
    (state_reg == APRC_CONV) && !readConvert |=> busyN;
  endproperty
  a_abort_release: assert property (p_abort_release)
    else $error("abort did not release busy");

  property p_start_busy;
    @(posedge clk_sys) disable iff (!nrst)
    busyN && !selectN && !readConvert && armed_reg |=> !busyN;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start did not raise busy");
endmodule
`default_nettype wire

// ---- bench/aprc_host.sv ----
// Host model driving the select, read/convert and byte-select lines
`timescale 1ns/1ps
`default_nettype none
module aprc_host
(
  input  wire logic           clk_sys,
  input  wire logic           busyN,
  input  wire aprc_pkg::aprc_word_t resultBusOut,
  output var  logic           selectN,
  output var  logic           readConvert,
  output var  logic           byteSel
);
  import aprc_pkg::*;
  initial
  begin
    selectN     = 1'b1;
    readConvert = 1'b1;
    byteSel     = 1'b0;
  end
  // Start, count busy cycles, sample mid-way and latch on busy rise
  task automatic convert(input logic late, output int cyc,
                         output aprc_word_t mid, output aprc_word_t pre,
                         output aprc_word_t lat);
    @(negedge clk_sys);
    readConvert = 1'b0;
    selectN     = late;
    if (late)
    begin
      @(negedge clk_sys);
      selectN = 1'b0;
    end
    @(negedge clk_sys);
    readConvert = 1'b1;
    cyc = 0;
    while (busyN === 1'b0 && cyc < 30)
    begin
      if (cyc == 14)
        mid = resultBusOut;
      pre = resultBusOut;
      @(negedge clk_sys);
      cyc++;
    end
    lat = resultBusOut;
    repeat (40) @(negedge clk_sys);
  endtask
  // Start, then pull read/convert low one cycle mid-conversion
  task automatic abort_conv(output int cyc);
    @(negedge clk_sys);
    readConvert = 1'b0;
    selectN     = 1'b0;
    @(negedge clk_sys);
    readConvert = 1'b1;
    repeat (5) @(negedge clk_sys);
    readConvert = 1'b0;
    cyc = 0;
    while (busyN === 1'b0 && cyc < 30)
    begin
      @(negedge clk_sys);
      cyc++;
    end
    readConvert = 1'b1;
    repeat (40) @(negedge clk_sys);
  endtask
  task automatic read_bus(input logic b, output aprc_word_t v);
    @(negedge clk_sys);
    byteSel = b;
    repeat (2) @(negedge clk_sys);
    v = resultBusOut;
  endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking testbench for the converter readout control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aprc_pkg::*;
  logic       clk_sys = 1'b0;
  logic       nrst;
  logic       sampleValid;
  aprc_word_t sampleData;
  logic       sampleReady;
  logic       busyN;
  aprc_word_t resultBusOut;
  logic       resultBusOe;
  logic       selectN;
  logic       readConvert;
  logic       byteSel;
  int         fails = 0;
  int         total_checks = 0;
  always #50 clk_sys = ~clk_sys;
  aprc_top dut (.clk_sys(clk_sys), .nrst(nrst), .selectN(selectN),
    .readConvert(readConvert), .byteSel(byteSel), .sampleData(sampleData),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .busyN(busyN),
    .resultBusOut(resultBusOut), .resultBusOe(resultBusOe));
  aprc_host host (.clk_sys(clk_sys), .busyN(busyN),
    .resultBusOut(resultBusOut), .selectN(selectN),
    .readConvert(readConvert), .byteSel(byteSel));
  // ==========================================================
  // Compare tasks
  task automatic check_word(input aprc_word_t got, exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, exp, input string m);
    check_word({15'h0000, got}, {15'h0000, exp}, m);
  endtask
  task automatic wrap_up;
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic aprc_word_t expv(input int i);
    aprc_word_t codes [4] = '{16'h7fff, 16'h0000, 16'hffff, 16'h8000};
    return (i < 4) ? codes[i] : (i > 15) ? 16'h0000 : aprc_word_t'(i * 'h1111);
  endfunction
  // ==========================================================
  // Scenarios
  task automatic oe_table;
    for (int i = 1; i < 4; i++)
    begin
      @(negedge clk_sys);
      host.selectN     = i[1];
      host.readConvert = i[0];
      #1 check_bit(resultBusOe, i[0] & ~i[1], "bus enable");
    end
  endtask
  task automatic abort_scn;
    int cyc;
    aprc_word_t v;
    host.abort_conv(cyc);
    check_bit(cyc inside {[1:3]}, 1'b1, "abort release");
    host.read_bus(1'b0, v);
    check_word(v, 16'h0000, "after abort");
  endtask
  task automatic fill_scn;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clk_sys);
      sampleValid = 1'b1;
      sampleData  = expv(i);
    end
    @(negedge clk_sys);
    sampleValid = 1'b0;
    check_bit(sampleReady, 1'b0, "fifo full");
  endtask
  task automatic drain_scn;
    int cyc;
    aprc_word_t mid, pre, lat, v, prev, e;
    prev = 16'h0000;
    for (int i = 0; i < 17; i++)
    begin
      e = expv(i);
      host.convert(i == 3, cyc, mid, pre, lat);
      check_bit(cyc inside {[1:20]}, 1'b1, "busy length");
      check_word(mid, prev, "held result");
      check_word(pre, e, "before busy rise");
      check_word(lat, e, "latched");
      host.read_bus(1'b1, v);
      check_word(v, {e[7:0], e[15:8]}, "bytes");
      host.read_bus(1'b0, v);
      check_word(v, e, "word");
      prev = e;
    end
  endtask
  initial
  begin
    nrst        = 1'b0;
    sampleValid = 1'b0;
    sampleData  = 16'h0000;
    repeat (20) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (2) @(negedge clk_sys);
    oe_table();
    abort_scn();
    fill_scn();
    drain_scn();
    wrap_up();
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
